/* common/aux_adc_map.vh */
`ifndef AUX_ADC_MAP_VH
`define AUX_ADC_MAP_VH

// ----------------------------------------------------------------------------
// Special function register addresses.
// ----------------------------------------------------------------------------
`define ADDR_TEMPERATURE_RESULT    8'hD7
`define ADDR_MEASUREMENT_START     8'hD8
`define ADDR_BATTERY_RESULT        8'hDF
`define ADDR_SUPPLY_RESULT         8'hEF
`define ADDR_DELTA_THRESHOLDS      8'hF3
`define ADDR_BACKGROUND_INTERVAL   8'hF9
`define ADDR_BATTERY_LOW_THRESHOLD 8'hFA

// ----------------------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------------------
`define RST_BYTE  8'h00
`define RST_START 3'h0
`define RST_DELTA 6'h00
`define RST_MIN   5'h00

// ----------------------------------------------------------------------------
// Channel indices, which are also the start bit positions.
// ----------------------------------------------------------------------------
`define CH_BATTERY 0
`define CH_TEMP    1
`define CH_SUPPLY  2

// ----------------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------------
`define START_MSB        2
`define TEMP_IVL_LSB     0
`define BATT_IVL_LSB     2
`define SUPPLY_IVL_LSB   4
`define SUPPLY_DELTA_LSB 0
`define TEMP_DELTA_LSB   3
`define DELTA_MSB        5

// ----------------------------------------------------------------------------
// Interval codes and their lengths in minutes.
// ----------------------------------------------------------------------------
`define IVL_OFF   2'h0
`define IVL_SLOW  2'h1
`define IVL_MID   2'h2
`define IVL_FAST  2'h3
`define MIN_TS_SLOW 5'h08
`define MIN_TS_MID  5'h02
`define MIN_B_SLOW  5'h10
`define MIN_B_MID   5'h04
`define MIN_FAST    5'h01

// ----------------------------------------------------------------------------
// Delta codes.
// ----------------------------------------------------------------------------
`define DELTA_NEVER 3'h0
`define DELTA_EVERY 3'h7

// ----------------------------------------------------------------------------
// Timing: clock cycles in one minute at the 40 MHz clock.
// ----------------------------------------------------------------------------
// Sixty seconds of 40 MHz cycles, given as one sized 32-bit value.
`define MINUTE_CYCLES_DFLT 32'h8F0D1800

`endif

/* dv/aux_adc_measurement_scheduler_tb.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin mismatches++; $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end

module aux_adc_measurement_scheduler_tb;
	logic       mclk_i = 1'b0, rst_i = 1'b1, sfr_wr_i = 1'b0, save_one = 1'b0, save_two = 1'b0, keep = 1'b0;
	logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, conv_data_i = 8'h00, sfr_rdata_o;
	logic [2:0] conv_ack_i = 3'h0, conv_done_i = 3'h0, conv_req_o;
	logic       temp_irq_o, battery_irq_o, supply_irq_o;
	logic [7:0] regs [7] = '{8'hD7, 8'hD8, 8'hDF, 8'hEF, 8'hF3, 8'hF9, 8'hFA};
	logic [7:0] res_a [3] = '{8'hDF, 8'hD7, 8'hEF};
	int         sh [3] = '{2, 0, 4};
	int         mins [3][3] = '{'{16, 4, 1}, '{8, 2, 1}, '{8, 2, 1}};
	int         mismatches = 0, check_count = 0, n;

	// A minute is shortened to ten clocks so that every interval fits the run.
	aux_adc_measurement_scheduler #(.MINUTE_CYCLES(32'h0000000A)) i_dut (
		.mclk_i(mclk_i), .rst_i(rst_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
		.sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o), .power_saving_mode_one_i(save_one),
		.power_saving_mode_two_i(save_two), .measure_in_psm_i(keep), .conv_req_o(conv_req_o),
		.conv_ack_i(conv_ack_i), .conv_done_i(conv_done_i), .conv_data_i(conv_data_i),
		.temp_irq_o(temp_irq_o), .battery_irq_o(battery_irq_o), .supply_irq_o(supply_irq_o));

	// ------------------------------------------------------------------------
	// Clock and bus tasks; all inputs change on the falling edge.
	// ------------------------------------------------------------------------
	initial forever #12.5 mclk_i = ~mclk_i;

	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk_i);
		sfr_addr_i = a;
		sfr_wdata_i = d;
		sfr_wr_i = 1'b1;
		@(negedge mclk_i);
		sfr_wr_i = 1'b0;
	endtask

	task rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge mclk_i);
		sfr_addr_i = a;
		@(negedge mclk_i);
		`CHK(sfr_rdata_o, e)
	endtask

	// Pulses acknowledges and checks which requests are left standing.
	task ack(input logic [2:0] b, input logic [2:0] e);
		@(negedge mclk_i);
		conv_ack_i = b;
		@(negedge mclk_i);
		conv_ack_i = 3'h0;
		`CHK(conv_req_o, e)
	endtask

	// One finished conversion; the address already points at its result.
	task step(input int ch, input logic [7:0] d, input logic e);
		@(negedge mclk_i);
		sfr_addr_i = res_a[ch];
		conv_done_i = 3'b001 << ch;
		conv_data_i = d;
		@(negedge mclk_i);
		conv_done_i = 3'h0;
		conv_data_i = ~d;
		`CHK({supply_irq_o, temp_irq_o, battery_irq_o}, e ? 3'b001 << ch : 3'h0)
		rd(res_a[ch], d);
	endtask

	// Counts falling edges until a request shows, then acknowledges it.
	task wait_req(input int ch);
		n = 0;
		while (conv_req_o[ch] !== 1'b1 && n < 400) begin
			@(negedge mclk_i);
			n++;
		end
		conv_ack_i = 3'b001 << ch;
		@(negedge mclk_i);
		conv_ack_i = 3'h0;
	endtask

	task wrap_up();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ------------------------------------------------------------------------
	// Test sequence.
	// ------------------------------------------------------------------------
	initial begin
		repeat (5) @(posedge mclk_i);
		@(negedge mclk_i);
		rst_i = 1'b0;
		foreach (regs[i]) rd(regs[i], 8'h00);
		// The pattern picks only the slowest intervals, so no background request
		// can start before the interval register is cleared again below.
		foreach (regs[i]) begin
			if (regs[i] != 8'hD8) begin
				wr(regs[i], 8'h15);
				rd(regs[i], 8'h15);
			end
		end
		wr(8'hF3, 8'hFF);
		rd(8'hF3, 8'h3F);
		wr(8'h01, 8'hA5);
		rd(8'h01, 8'h00);
		foreach (regs[i]) wr(regs[i], 8'h00);
		$display("test registers done");
		wr(8'hD8, 8'hFD);
		`CHK(conv_req_o, 3'b101)
		rd(8'hD8, 8'h05);
		ack(3'b001, 3'b100);
		wr(8'hD8, 8'h00);
		`CHK(conv_req_o, 3'b100)
		ack(3'b100, 3'b000);
		$display("test start bits done");
		wr(8'hF3, 8'h38);
		step(1, 8'h40, 1'b1);
		step(2, 8'h55, 1'b0);
		wr(8'hF3, 8'h19);
		step(1, 8'h42, 1'b0);
		step(1, 8'h43, 1'b1);
		step(1, 8'h41, 1'b0);
		step(1, 8'h40, 1'b1);
		step(2, 8'h00, 1'b0);
		step(2, 8'h01, 1'b1);
		wr(8'hF3, 8'h07);
		step(2, 8'h01, 1'b1);
		step(1, 8'hFF, 1'b0);
		wr(8'hFA, 8'h80);
		step(0, 8'h7F, 1'b1);
		step(0, 8'h80, 1'b0);
		$display("test interrupts done");
		for (int ch = 0; ch < 3; ch++) begin
			for (int c = 1; c < 4; c++) begin
				wr(8'hF9, 8'(c << sh[ch]));
				wait_req(ch);
				wait_req(ch);
				`CHK(n + 1, 10 * mins[ch][c - 1])
				wr(8'hF9, 8'h00);
			end
		end
		$display("test intervals done");
		wr(8'hF9, 8'h03);
		save_one = 1'b1;
		repeat (30) @(negedge mclk_i);
		`CHK(conv_req_o, 3'h0)
		keep = 1'b1;
		wait_req(1);
		`CHK(n < 12, 1'b1)
		save_one = 1'b0;
		save_two = 1'b1;
		wait_req(1);
		`CHK(n + 1, 10)
		keep = 1'b0;
		repeat (30) @(negedge mclk_i);
		`CHK(conv_req_o, 3'h0)
		save_two = 1'b0;
		wr(8'hF9, 8'h00);
		$display("test power saving done");
		wrap_up();
	end

	// Watchdog: the sequence needs under two thousand clocks.
	initial begin
		#(25 * 4000);
		mismatches++;
		wrap_up();
	end
endmodule

/* dv/aux_adc_properties.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Port checker for the measurement scheduler.
// ----------------------------------------------------------------------------
module aux_adc_properties (
	input logic       mclk_i,
	input logic       rst_i,
	input logic [7:0] sfr_addr_i,
	input logic       sfr_wr_i,
	input logic [7:0] sfr_wdata_i,
	input logic [7:0] sfr_rdata_o,
	input logic [2:0] conv_req_o,
	input logic [2:0] conv_ack_i,
	input logic [2:0] conv_done_i,
	input logic [7:0] conv_data_i,
	input logic       temp_irq_o,
	input logic       battery_irq_o,
	input logic       supply_irq_o
);
	// All checks share the one clock and the asynchronous reset.
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	a_req_set: assert property (sfr_wr_i && sfr_addr_i == 8'hD8 |=>
		(conv_req_o & $past(sfr_wdata_i[2:0])) == $past(sfr_wdata_i[2:0])) else $error("start bit not raised");
	a_req_hold: assert property (1'b1 |=>
		(conv_req_o & $past(conv_req_o & ~conv_ack_i)) == $past(conv_req_o & ~conv_ack_i)) else $error("request dropped");
	a_start_read: assert property (sfr_addr_i == 8'hD8 |=> sfr_rdata_o[7:3] == 5'h00)
		else $error("start register upper bits not zero");
	a_temp_irq_src: assert property (temp_irq_o |-> $past(conv_done_i[1]))
		else $error("temperature irq without conversion");
	a_supply_irq_src: assert property (supply_irq_o |-> $past(conv_done_i[2]))
		else $error("supply irq without conversion");
	a_batt_irq_src: assert property (battery_irq_o |-> $past(conv_done_i[0]))
		else $error("battery irq without conversion");
	a_irq_single: assert property ($onehot0({supply_irq_o, temp_irq_o, battery_irq_o}))
		else $error("more than one irq at once");
	a_result_load: assert property (conv_done_i[1] ##1 sfr_addr_i == 8'hD7 |=>
		sfr_rdata_o == $past(conv_data_i, 2)) else $error("temperature result not loaded");
	a_unmapped_zero: assert property (!(sfr_addr_i inside {8'hD7, 8'hD8, 8'hDF, 8'hEF, 8'hF3, 8'hF9, 8'hFA})
		|=> sfr_rdata_o == 8'h00) else $error("unmapped read not zero");
endmodule

bind aux_adc_measurement_scheduler aux_adc_properties i_props (.mclk_i(mclk_i), .rst_i(rst_i),
	.sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
	.conv_req_o(conv_req_o), .conv_ack_i(conv_ack_i), .conv_done_i(conv_done_i), .conv_data_i(conv_data_i),
	.temp_irq_o(temp_irq_o), .battery_irq_o(battery_irq_o), .supply_irq_o(supply_irq_o));

/* rtl/aux_adc_measurement_scheduler.v */
`timescale 1ns/1ps
`include "aux_adc_map.vh"

module aux_adc_measurement_scheduler #(
	parameter [31:0] MINUTE_CYCLES = `MINUTE_CYCLES_DFLT
) (
	input  wire        mclk_i,
	input  wire        rst_i,
	input  wire [7:0]  sfr_addr_i,
	input  wire        sfr_wr_i,
	input  wire [7:0]  sfr_wdata_i,
	output reg  [7:0]  sfr_rdata_o,
	input  wire        power_saving_mode_one_i,
	input  wire        power_saving_mode_two_i,
	input  wire        measure_in_psm_i,
	output reg  [2:0]  conv_req_o,
	input  wire [2:0]  conv_ack_i,
	input  wire [2:0]  conv_done_i,
	input  wire [7:0]  conv_data_i,
	output reg         temp_irq_o,
	output reg         battery_irq_o,
	output reg         supply_irq_o
);

	// ------------------------------------------------------------------------
	// Register state.
	// ------------------------------------------------------------------------
	reg [7:0]  background_interval_r;   // Interval fields, stored as written.
	reg [5:0]  delta_thresholds_r;      // Temperature and supply delta fields.
	reg [7:0]  battery_low_threshold_r; // Low battery compare level.
	reg [7:0]  temperature_result_r;    // Latest temperature result.
	reg [7:0]  battery_result_r;        // Latest battery result.
	reg [7:0]  supply_result_r;         // Latest supply result.
	reg [7:0]  last_temp_r;             // Temperature that last interrupted.
	reg [7:0]  last_supply_r;           // Supply reading that last interrupted.
	reg [31:0] prescale_r;              // Cycle count within one minute.
	reg [4:0]  minutes_r [0:2];         // Minutes elapsed per channel.
	reg [2:0]  start_nxt;               // Next value of the start bits.
	reg [2:0]  fire;                    // Background request per channel.
	reg [7:0]  rdata_nxt;               // Read mux.
	integer    i;                       // Loop index of the request decode.
	integer    j;                       // Loop index of the minute counters.

	// Decoded fields.
	wire [1:0] supply_ivl = background_interval_r[`SUPPLY_IVL_LSB+1:`SUPPLY_IVL_LSB];
	wire [1:0] batt_ivl   = background_interval_r[`BATT_IVL_LSB+1:`BATT_IVL_LSB];
	wire [1:0] temp_ivl   = background_interval_r[`TEMP_IVL_LSB+1:`TEMP_IVL_LSB];
	wire [2:0] temp_delta   = delta_thresholds_r[`DELTA_MSB:`TEMP_DELTA_LSB];
	wire [2:0] supply_delta = delta_thresholds_r[`TEMP_DELTA_LSB-1:`SUPPLY_DELTA_LSB];

	// Timers run outside the power-saving modes, or inside them when allowed.
	wire timers_run = ~(power_saving_mode_one_i | power_saving_mode_two_i) | measure_in_psm_i;
	wire minute_tick = timers_run & (prescale_r == MINUTE_CYCLES - 32'h1);

	// Software write strobes.
	wire wr_start = sfr_wr_i & (sfr_addr_i == `ADDR_MEASUREMENT_START);

	// ------------------------------------------------------------------------
	// Helpers.
	// ------------------------------------------------------------------------
	// Returns the interval length in minutes, or zero when the channel is off.
	function [4:0] interval_minutes;
		input [1:0] code;
		input       is_battery;
		begin
			case (code)
				`IVL_SLOW: interval_minutes = is_battery ? `MIN_B_SLOW : `MIN_TS_SLOW;
				`IVL_MID:  interval_minutes = is_battery ? `MIN_B_MID : `MIN_TS_MID;
				`IVL_FAST: interval_minutes = `MIN_FAST;
				default:   interval_minutes = `RST_MIN;
			endcase
		end
	endfunction

	// Decides whether a new reading interrupts, given the last one and a code.
	function delta_hit;
		input [7:0] now_val;
		input [7:0] last_val;
		input [2:0] code;
		reg   [7:0] diff;
		begin
			diff = (now_val > last_val) ? (now_val - last_val) : (last_val - now_val);
			if (code == `DELTA_NEVER)
				delta_hit = 1'b0;
			else if (code == `DELTA_EVERY)
				delta_hit = 1'b1;
			else
				delta_hit = (diff >= {5'h00, code});
		end
	endfunction

	// Interval selected for each channel.
	wire [4:0] ivl_min [0:2];
	assign ivl_min[`CH_BATTERY] = interval_minutes(batt_ivl, 1'b1);
	assign ivl_min[`CH_TEMP]    = interval_minutes(temp_ivl, 1'b0);
	assign ivl_min[`CH_SUPPLY]  = interval_minutes(supply_ivl, 1'b0);

	// Interrupt decisions on a completed conversion.
	wire temp_hit   = conv_done_i[`CH_TEMP] & delta_hit(conv_data_i, last_temp_r, temp_delta);
	wire supply_hit = conv_done_i[`CH_SUPPLY] & delta_hit(conv_data_i, last_supply_r, supply_delta);
	wire batt_hit   = conv_done_i[`CH_BATTERY] & (conv_data_i < battery_low_threshold_r);

	// ------------------------------------------------------------------------
	// Minute prescaler.
	// ------------------------------------------------------------------------
	// Counts clock cycles into minutes; holds while the timers are halted.
	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			prescale_r <= 32'h0;
		end else if (minute_tick) begin
			prescale_r <= 32'h0;
		end else if (timers_run) begin
			prescale_r <= prescale_r + 32'h1;
		end
	end

	// ------------------------------------------------------------------------
	// Per-channel interval counters.
	// ------------------------------------------------------------------------
	// A channel fires on the minute tick that completes its interval.
	always @* begin
		fire = 3'h0;
		for (i = 0; i < 3; i = i + 1) begin
			fire[i] = minute_tick & (ivl_min[i] != `RST_MIN) & (minutes_r[i] + 5'h01 >= ivl_min[i]);
		end
	end

	// Counts whole minutes per channel and restarts while the channel is off.
	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			for (j = 0; j < 3; j = j + 1) begin
				minutes_r[j] <= `RST_MIN;
			end
		end else begin
			for (j = 0; j < 3; j = j + 1) begin
				if ((ivl_min[j] == `RST_MIN) || fire[j]) begin
					minutes_r[j] <= `RST_MIN;
				end else if (minute_tick) begin
					minutes_r[j] <= minutes_r[j] + 5'h01;
				end
			end
		end
	end

	// ------------------------------------------------------------------------
	// Start bits and converter requests.
	// ------------------------------------------------------------------------
	// Acceptance clears a bit, but a new set in the same cycle wins.
	always @* begin
		start_nxt = conv_req_o & ~conv_ack_i;
		if (wr_start) begin
			start_nxt = start_nxt | sfr_wdata_i[`START_MSB:0];
		end
		start_nxt = start_nxt | fire;
	end

	// The start bits drive the request lines directly.
	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			conv_req_o <= `RST_START;
		end else begin
			conv_req_o <= start_nxt;
		end
	end

	// ------------------------------------------------------------------------
	// Configuration registers.
	// ------------------------------------------------------------------------
	// Software writes to the configuration registers.
	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			background_interval_r   <= `RST_BYTE;
			delta_thresholds_r      <= `RST_DELTA;
			battery_low_threshold_r <= `RST_BYTE;
		end else if (sfr_wr_i) begin
			case (sfr_addr_i)
				`ADDR_BACKGROUND_INTERVAL:   background_interval_r   <= sfr_wdata_i;
				`ADDR_DELTA_THRESHOLDS:      delta_thresholds_r      <= sfr_wdata_i[`DELTA_MSB:0];
				`ADDR_BATTERY_LOW_THRESHOLD: battery_low_threshold_r <= sfr_wdata_i;
				default: begin
				end
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// Result registers and interrupt references.
	// ------------------------------------------------------------------------
	// A completed conversion wins over a software write to the same register.
	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			temperature_result_r <= `RST_BYTE;
			battery_result_r     <= `RST_BYTE;
			supply_result_r      <= `RST_BYTE;
			last_temp_r          <= `RST_BYTE;
			last_supply_r        <= `RST_BYTE;
		end else begin
			if (conv_done_i[`CH_TEMP]) begin
				temperature_result_r <= conv_data_i;
			end else if (sfr_wr_i && (sfr_addr_i == `ADDR_TEMPERATURE_RESULT)) begin
				temperature_result_r <= sfr_wdata_i;
			end
			if (conv_done_i[`CH_BATTERY]) begin
				battery_result_r <= conv_data_i;
			end else if (sfr_wr_i && (sfr_addr_i == `ADDR_BATTERY_RESULT)) begin
				battery_result_r <= sfr_wdata_i;
			end
			if (conv_done_i[`CH_SUPPLY]) begin
				supply_result_r <= conv_data_i;
			end else if (sfr_wr_i && (sfr_addr_i == `ADDR_SUPPLY_RESULT)) begin
				supply_result_r <= sfr_wdata_i;
			end
			// Only an interrupting reading becomes the new reference.
			if (temp_hit) begin
				last_temp_r <= conv_data_i;
			end
			if (supply_hit) begin
				last_supply_r <= conv_data_i;
			end
		end
	end

	// ------------------------------------------------------------------------
	// Interrupt pulses.
	// ------------------------------------------------------------------------
	// Each interrupt is a one-cycle pulse in the cycle the result loads.
	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			temp_irq_o    <= 1'b0;
			battery_irq_o <= 1'b0;
			supply_irq_o  <= 1'b0;
		end else begin
			temp_irq_o    <= temp_hit;
			battery_irq_o <= batt_hit;
			supply_irq_o  <= supply_hit;
		end
	end

	// ------------------------------------------------------------------------
	// Read port.
	// ------------------------------------------------------------------------
	// Selects the addressed register; unmapped reads and unused start and delta bits are zero.
	always @* begin
		case (sfr_addr_i)
			`ADDR_TEMPERATURE_RESULT:    rdata_nxt = temperature_result_r;
			`ADDR_MEASUREMENT_START:     rdata_nxt = {5'h00, conv_req_o};
			`ADDR_BATTERY_RESULT:        rdata_nxt = battery_result_r;
			`ADDR_SUPPLY_RESULT:         rdata_nxt = supply_result_r;
			`ADDR_DELTA_THRESHOLDS:      rdata_nxt = {2'h0, delta_thresholds_r};
			`ADDR_BACKGROUND_INTERVAL:   rdata_nxt = background_interval_r;
			`ADDR_BATTERY_LOW_THRESHOLD: rdata_nxt = battery_low_threshold_r;
			default:                     rdata_nxt = `RST_BYTE;
		endcase
	end

	// Read data is registered, one cycle behind the address.
	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			sfr_rdata_o <= `RST_BYTE;
		end else begin
			sfr_rdata_o <= rdata_nxt;
		end
	end

endmodule
